// ### rtl/swt_pkg.sv
// package for the single wire bus transceiver control block
// assumes one 100 MHz core clock and synchronous pin inputs
package swt_pkg;

    // ****************************************************
    // modes and timing
    // ****************************************************
    // gray order: sleep, wake-up, normal, high speed
    typedef enum logic [1:0] {
        SWT_SLEEP = 2'b00,
        SWT_WAKE = 2'b01,
        SWT_NORMAL = 2'b11,
        SWT_HSPEED = 2'b10
    } swt_mode_e;

    // drive level encoding for the bus output
    typedef enum logic [1:0] {
        SWT_DRV_REC = 2'b00,
        SWT_DRV_NORM = 2'b01,
        SWT_DRV_HIGH = 2'b10
    } swt_drv_e;

    localparam int unsigned SWT_CLK_MHZ = 100;
    localparam int unsigned SWT_TIMEOUT_US = 1000;
    localparam int unsigned SWT_TIMEOUT_CYC = SWT_TIMEOUT_US * SWT_CLK_MHZ;
    localparam int SWT_CNT_W = 24;
    localparam int SWT_BUF_DEPTH = 2;
    localparam logic SWT_RX_RESET = 1'b1;
    localparam logic SWT_TX_RESET = 1'b1;

endpackage

// ### rtl/swt_ctrl.sv
// control logic of a single wire bus transceiver: mode decode, transmit
// drive with stuck-dominant timeout, receive gating and wake flagging,
// supply, thermal and ground lockouts
// assumes analog comparators deliver bus and fault levels on core_clk
//
// Contract
// - transmit high or open leaves the bus recessive
// - transmit low drives dominant, elevated level in wake-up mode
// - sleep mode never drives the bus dominant
// - transmit input defaults high via weak pull-up
// - transmit dominant past timeout switches bus drive off
// - next low-to-high transmit edge re-enables drive at once
// - mode inputs decode to sleep, high speed, wake-up, normal
// - mode inputs default low via pull-downs, giving sleep
// - sleep holds until elevated bus voltage or mode change
// - high speed mode disables shaping, normal dominant level
// - elevated bus voltage wakes a sleeping node, normal does not
// - normal mode keeps edge shaping active
// - receive output high for recessive, low for dominant bus
// - sleep forwards nothing until wake voltage or mode change
// - bus wake-up pulls receive output low as an interrupt
// - wake with modes low returns to sleep when wake voltage ends
// - all other modes pass bus state to receive output
// - receive output undriven while sleeping
// - load ground path closed except on loss of ground
// - undervoltage keeps bus passive and receive undriven high
// - over-temperature disables the high-side driver
// - loss of ground opens load but keeps transmitting
`timescale 1ns/10ps
module swt_ctrl #(
    parameter int unsigned TIMEOUT_CYC = swt_pkg::SWT_TIMEOUT_CYC
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic tx_data,
    input wire logic tx_data_oe,
    input wire logic mode_sel_a,
    input wire logic mode_sel_a_oe,
    input wire logic mode_sel_b,
    input wire logic mode_sel_b_oe,
    input wire logic bus_dom_norm,
    input wire logic bus_dom_high,
    input wire logic supply_low,
    input wire logic over_temp,
    input wire logic ground_lost,
    input wire logic rx_ready,
    output logic rx_valid,
    output logic rx_data,
    output logic rx_data_oe,
    output logic rx_wake,
    output logic single_bus_line,
    output logic single_bus_line_oe,
    output logic [1:0] bus_drive_level,
    output logic shaping_en,
    output logic load_gnd_closed,
    output logic tx_timed_out,
    output logic [1:0] mode_state
);

    // ****************************************************
    // state
    // ****************************************************
    typedef struct packed {
        logic [1:0] tx_sync;
        logic [1:0] ma_sync;
        logic [1:0] mb_sync;
        logic tx_prev;
        logic [swt_pkg::SWT_CNT_W-1:0] dom_cnt;
        logic timed_out;
        swt_pkg::swt_mode_e mode;
        logic woken;
        logic [1:0] buf_data;
        logic [1:0] buf_wake;
        logic [1:0] buf_cnt;
        logic rd_ptr;
        logic wr_ptr;
        logic last_rx;
        logic [1:0] drv;
        logic drv_on;
        logic shape;
        logic load_on;
    } swt_state_s;

    swt_state_s st_reg;
    swt_state_s st_next;

    localparam logic [swt_pkg::SWT_CNT_W-1:0] TO_LIMIT = swt_pkg::SWT_CNT_W'(TIMEOUT_CYC);

    logic tx_pin;
    logic ma_pin;
    logic mb_pin;
    logic tx_s;
    logic [1:0] msel;
    logic rx_level;
    logic rx_wk;
    logic push;
    logic pop;
    logic sleeping;

    // ****************************************************
    // pin defaults
    // ****************************************************
    always_comb begin
        tx_pin = tx_data_oe ? tx_data : 1'b1;
        ma_pin = mode_sel_a_oe ? mode_sel_a : 1'b0;
        mb_pin = mode_sel_b_oe ? mode_sel_b : 1'b0;
    end

    // ****************************************************
    // next state
    // ****************************************************
    always_comb begin
        st_next = st_reg;
        st_next.tx_sync = {st_reg.tx_sync[0], tx_pin};
        st_next.ma_sync = {st_reg.ma_sync[0], ma_pin};
        st_next.mb_sync = {st_reg.mb_sync[0], mb_pin};
        tx_s = st_reg.tx_sync[1];
        msel = {st_reg.mb_sync[1], st_reg.ma_sync[1]};
        st_next.tx_prev = tx_s;

        case (msel)
            2'b01: st_next.mode = swt_pkg::SWT_HSPEED;
            2'b10: st_next.mode = swt_pkg::SWT_WAKE;
            2'b11: st_next.mode = swt_pkg::SWT_NORMAL;
            default: st_next.mode = swt_pkg::SWT_SLEEP;
        endcase

        if (st_reg.mode == swt_pkg::SWT_SLEEP && !st_reg.woken && bus_dom_high) begin
            st_next.woken = 1'b1;
        // back to sleep when wake level gone
        end else if (!bus_dom_high || msel != 2'b00) begin
            st_next.woken = 1'b0;
        end
        sleeping = (st_reg.mode == swt_pkg::SWT_SLEEP) && !st_reg.woken;

        if (tx_s) begin
            st_next.dom_cnt = '0;
        end else if (st_reg.dom_cnt != TO_LIMIT) begin
            st_next.dom_cnt = st_reg.dom_cnt + 1'b1;
        end
        if (!tx_s && st_reg.dom_cnt == TO_LIMIT) begin
            st_next.timed_out = 1'b1;
        end else if (tx_s && !st_reg.tx_prev) begin
            st_next.timed_out = 1'b0;
        end

        if (tx_s || st_reg.mode == swt_pkg::SWT_SLEEP || st_reg.timed_out
            || supply_low || over_temp) begin
            st_next.drv = swt_pkg::SWT_DRV_REC;
        end else if (st_reg.mode == swt_pkg::SWT_WAKE) begin
            st_next.drv = swt_pkg::SWT_DRV_HIGH;
        end else begin
            st_next.drv = swt_pkg::SWT_DRV_NORM;
        end
        // loss of ground does not stop transmit
        st_next.drv_on = (st_next.drv != swt_pkg::SWT_DRV_REC);
        // shaping off only in high speed
        st_next.shape = (st_reg.mode != swt_pkg::SWT_HSPEED);
        // load path opens only on lost ground
        st_next.load_on = !ground_lost;

        rx_level = !(bus_dom_norm || bus_dom_high);
        // wake shows as a low receive output
        rx_wk = st_reg.woken && st_reg.mode == swt_pkg::SWT_SLEEP;

        // receive buffer: two entries, a change is a word
        // nothing is queued while sleeping
        push = !sleeping && !supply_low && (rx_level != st_reg.last_rx);
        pop = (st_reg.buf_cnt != 2'd0) && rx_ready;
        if (push && st_reg.buf_cnt != 2'(swt_pkg::SWT_BUF_DEPTH)) begin
            st_next.buf_data[st_reg.wr_ptr] = rx_wk ? 1'b0 : rx_level;
            st_next.buf_wake[st_reg.wr_ptr] = rx_wk;
            st_next.wr_ptr = ~st_reg.wr_ptr;
            st_next.last_rx = rx_level;
        end else if (push) begin
            // full: hold off, retry next cycle; a change undone while full is lost
            push = 1'b0;
        end
        if (pop) begin
            st_next.rd_ptr = ~st_reg.rd_ptr;
        end
        st_next.buf_cnt = st_reg.buf_cnt + 2'(push) - 2'(pop);
        if (supply_low || sleeping) begin
            st_next.last_rx = 1'b1;
        end
    end

    // ****************************************************
    // registers
    // ****************************************************
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            st_reg <= '{tx_sync: 2'b11, ma_sync: 2'b00, mb_sync: 2'b00,
                        tx_prev: swt_pkg::SWT_TX_RESET, dom_cnt: '0,
                        timed_out: 1'b0, mode: swt_pkg::SWT_SLEEP, woken: 1'b0,
                        buf_data: 2'b11, buf_wake: 2'b00, buf_cnt: 2'b00,
                        rd_ptr: 1'b0, wr_ptr: 1'b0,
                        last_rx: swt_pkg::SWT_RX_RESET, drv: swt_pkg::SWT_DRV_REC,
                        drv_on: 1'b0, shape: 1'b1, load_on: 1'b1};
        end else begin
            st_reg <= st_next;
        end
    end

    // ****************************************************
    // outputs
    // ****************************************************
    assign rx_valid = (st_reg.buf_cnt != 2'd0);
    assign rx_data = st_reg.buf_data[st_reg.rd_ptr];
    assign rx_wake = st_reg.buf_wake[st_reg.rd_ptr] && rx_valid;
    // receive undriven while sleeping or in supply undervoltage
    assign rx_data_oe = !(st_reg.mode == swt_pkg::SWT_SLEEP && !st_reg.woken) && !supply_low;
    assign single_bus_line = st_reg.drv_on;
    assign single_bus_line_oe = st_reg.drv_on;
    assign bus_drive_level = st_reg.drv;
    assign shaping_en = st_reg.shape;
    assign load_gnd_closed = st_reg.load_on;
    assign tx_timed_out = st_reg.timed_out;
    assign mode_state = st_reg.mode;

endmodule

// ### sim/swt_ctrl_sva.sv
// checker for the transceiver control ports
// assumes it is bound to swt_ctrl on the single core clock
`timescale 1ns/10ps
module swt_ctrl_sva #(
    parameter int unsigned TIMEOUT_CYC = 20
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic tx_data,
    input wire logic tx_data_oe,
    input wire logic mode_sel_a,
    input wire logic mode_sel_a_oe,
    input wire logic mode_sel_b,
    input wire logic mode_sel_b_oe,
    input wire logic supply_low,
    input wire logic over_temp,
    input wire logic ground_lost,
    input wire logic rx_valid,
    input wire logic rx_data,
    input wire logic rx_data_oe,
    input wire logic rx_wake,
    input wire logic single_bus_line,
    input wire logic single_bus_line_oe,
    input wire logic [1:0] bus_drive_level,
    input wire logic shaping_en,
    input wire logic load_gnd_closed,
    input wire logic tx_timed_out,
    input wire logic [1:0] mode_state
);
    // ****************************************************
    // properties
    // ****************************************************
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    logic [1:0] pins;
    logic [31:0] dom_cnt_reg;
    // open pins read low, so a floating pin counts as 0
    assign pins = {mode_sel_a & mode_sel_a_oe, mode_sel_b & mode_sel_b_oe};
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn)
            dom_cnt_reg <= '0;
        else
            dom_cnt_reg <= single_bus_line ? dom_cnt_reg + 32'h0000_0001 : '0;
    end
    sequence pins_held;
        $stable(pins)[*4];
    endsequence
    sequence tx_rec_held;
        (!tx_data_oe || tx_data)[*4];
    endsequence
    sleep_no_drive_a: assert property (mode_state == 2'h0 && $past(mode_state) == 2'h0
        |-> !single_bus_line) else $error("bus driven in sleep");
    norm_level_a: assert property (single_bus_line && mode_state[1]
        && $past(mode_state) == mode_state |-> bus_drive_level == swt_pkg::SWT_DRV_NORM)
        else $error("normal or high speed level wrong");
    hs_shape_a: assert property (mode_state == 2'h2 && $past(mode_state) == 2'h2
        |-> !shaping_en) else $error("shaping on in high speed");
    wake_level_a: assert property (single_bus_line && mode_state == 2'h1
        && $past(mode_state) == 2'h1 |-> bus_drive_level == swt_pkg::SWT_DRV_HIGH)
        else $error("wake mode level not elevated");
    mode_decode_a: assert property (pins_held |-> mode_state == pins)
        else $error("mode decode wrong");
    tx_recessive_a: assert property (tx_rec_held |=> !single_bus_line)
        else $error("bus driven with transmit high");
    timeout_bound_a: assert property (dom_cnt_reg <= TIMEOUT_CYC + 3)
        else $error("dominant too long");
    timeout_off_a: assert property (tx_timed_out |=> !single_bus_line)
        else $error("drive on after timeout");
    uv_lock_a: assert property (supply_low |-> !rx_data_oe ##1 !single_bus_line)
        else $error("undervoltage lockout broken");
    hot_off_a: assert property (over_temp |=> !single_bus_line)
        else $error("drive on when hot");
    load_path_a: assert property (load_gnd_closed == !$past(ground_lost))
        else $error("load path wrong");
    wake_word_a: assert property (rx_valid && rx_wake |-> !rx_data)
        else $error("wake word not low");
endmodule
bind swt_ctrl swt_ctrl_sva #(.TIMEOUT_CYC(TIMEOUT_CYC)) i_sva (
    .core_clk(core_clk),
    .resetn(resetn),
    .tx_data(tx_data),
    .tx_data_oe(tx_data_oe),
    .mode_sel_a(mode_sel_a),
    .mode_sel_a_oe(mode_sel_a_oe),
    .mode_sel_b(mode_sel_b),
    .mode_sel_b_oe(mode_sel_b_oe),
    .supply_low(supply_low),
    .over_temp(over_temp),
    .ground_lost(ground_lost),
    .rx_valid(rx_valid),
    .rx_data(rx_data),
    .rx_data_oe(rx_data_oe),
    .rx_wake(rx_wake),
    .single_bus_line(single_bus_line),
    .single_bus_line_oe(single_bus_line_oe),
    .bus_drive_level(bus_drive_level),
    .shaping_en(shaping_en),
    .load_gnd_closed(load_gnd_closed),
    .tx_timed_out(tx_timed_out),
    .mode_state(mode_state)
);

// ### sim/swt_host.sv
// host side model: takes receive words, can stall
// assumes the receive stream of swt_ctrl on the same clock
`timescale 1ns/10ps
module swt_host (
    input wire logic core_clk,
    input wire logic stall,
    input wire logic rx_valid,
    input wire logic rx_data,
    input wire logic rx_wake,
    output logic rx_ready,
    output logic [7:0] hist
);
    // a stall holds ready low so the buffer must keep up to two words
    assign rx_ready = !stall;
    always @(posedge core_clk) begin
        if (rx_valid && rx_ready)
            hist <= {hist[5:0], rx_wake, rx_data};
    end
endmodule

// ### sim/testbench.sv
// testbench for the transceiver control block
// assumes swt_ctrl, swt_host and the bound checker
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin miscompares++; \
    $display("Error %s exp %h got %h", nm, e, g); end end
module testbench;
    localparam int unsigned TO = 20;
    logic core_clk, resetn, tx, tx_oe, ma, ma_oe, mb, mb_oe, dnorm, dhigh, uv, hot, gl;
    logic stall, rx_ready, rx_valid, rx_data, rx_oe, rx_wake, bus, boe, shp, load, tmo;
    logic [1:0] lvl, mode;
    logic [7:0] hist;
    int miscompares = 0, n_tests = 0, cyc = 0;
    swt_ctrl #(.TIMEOUT_CYC(TO)) i_dut (.core_clk(core_clk), .resetn(resetn),
        .tx_data(tx), .tx_data_oe(tx_oe), .mode_sel_a(ma), .mode_sel_a_oe(ma_oe),
        .mode_sel_b(mb), .mode_sel_b_oe(mb_oe), .bus_dom_norm(dnorm), .bus_dom_high(dhigh),
        .supply_low(uv), .over_temp(hot), .ground_lost(gl), .rx_ready(rx_ready),
        .rx_valid(rx_valid), .rx_data(rx_data), .rx_data_oe(rx_oe), .rx_wake(rx_wake),
        .single_bus_line(bus), .single_bus_line_oe(boe), .bus_drive_level(lvl),
        .shaping_en(shp), .load_gnd_closed(load), .tx_timed_out(tmo), .mode_state(mode));
    swt_host i_host (.core_clk(core_clk), .stall(stall), .rx_valid(rx_valid),
        .rx_data(rx_data), .rx_wake(rx_wake), .rx_ready(rx_ready), .hist(hist));
    initial begin
        core_clk = 0;
        forever #5 core_clk = ~core_clk;
    end
    task automatic w(int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic pins(logic a, logic b);
        {ma, mb, ma_oe, mb_oe} = {a, b, 2'h3};
        w(5);
    endtask
    task automatic t_modes();
        swt_pkg::swt_mode_e ex[4] = '{swt_pkg::SWT_SLEEP, swt_pkg::SWT_HSPEED,
            swt_pkg::SWT_WAKE, swt_pkg::SWT_NORMAL};
        for (int i = 0; i < 4; i++) begin
            pins(i[0], i[1]);
            `CHK("mode", ex[i], mode)
        end
        {ma_oe, mb_oe} = 2'h0;
        w(5);
        `CHK("open mode", 2'h0, mode)
        `CHK("sleep oe", 1'b0, rx_oe)
    endtask
    task automatic t_tx();
        logic [1:0] lv[4] = '{2'h0, 2'h1, 2'h2, 2'h1};
        for (int i = 0; i < 4; i++) begin
            pins(i[0], i[1]);
            tx = 0;
            w(4);
            `CHK("level", lv[i], lvl)
            `CHK("shaping", (i != 1), shp)
            // low level left behind an open pin must read high
            tx_oe = 0;
            w(4);
            `CHK("open tx", 2'h0, lvl)
            tx_oe = 1;
            tx = 1;
        end
    endtask
    task automatic t_timeout();
        pins(1, 1);
        `CHK("norm shape", 1'b1, shp)
        tx = 0;
        w(4);
        w(TO + 4);
        `CHK("timeout", 3'h1, {bus, boe, tmo})
        tx = 1;
        w(4);
        tx = 0;
        w(4);
        `CHK("resume", 3'h6, {bus, boe, tmo})
        {uv, tx} = 2'h2;
        w(2);
        `CHK("uv", 2'h0, {bus, rx_oe})
        {uv, hot} = 2'h1;
        w(2);
        `CHK("hot", 1'b0, bus)
        {hot, gl} = 2'h1;
        w(3);
        `CHK("gnd lost", 2'h2, {bus, load})
        {gl, tx} = 2'h1;
        w(2);
        `CHK("gnd back", 1'b1, load)
    endtask
    task automatic t_rx();
        stall = 1;
        for (int i = 0; i < 3; i++) begin
            dnorm = ~dnorm;
            w(4);
        end
        `CHK("held", 1'b1, rx_valid)
        stall = 0;
        w(6);
        `CHK("words", 6'h04, hist[5:0])
        dnorm = 0;
        pins(0, 0);
        dnorm = 1;
        w(4);
        `CHK("sleep rx", 1'b0, rx_oe)
        `CHK("sleep fwd", 1'b0, rx_valid)
        `CHK("sleep hold", 2'h0, mode)
        dnorm = 0;
        dhigh = 1;
        w(5);
        `CHK("wake", 3'h6, {rx_oe, hist[1:0]})
        dhigh = 0;
        w(5);
        `CHK("resleep", 1'b0, rx_oe)
    endtask
    task automatic print_verdict();
        $display("tests %0d miscompares %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    always @(posedge core_clk) begin
        cyc++;
        if (cyc > 2000) begin
            miscompares++;
            print_verdict();
        end
    end
    initial begin
        {resetn, tx, tx_oe, ma, ma_oe, mb, mb_oe} = 7'h30;
        {dnorm, dhigh, uv, hot, gl, stall} = 6'h00;
        w(3);
        `CHK("reset level", 2'h0, lvl)
        resetn = 1;
        t_modes();
        t_tx();
        t_timeout();
        t_rx();
        print_verdict();
    end
endmodule
